// *** verilog/fsc_top.v ***
// Flash strobe control: lamp source selection, duty modulation, flash counter,
// unlock-protected non-volatile byte, strobe filter/timeout/stretch, self test,
// fault latching with standby entry and an open-drain interrupt.
// Assumes register accesses arrive as single-cycle strobes already decoded
// from the serial interface, and that fault detectors deliver level inputs.
`timescale 1ns/100ps
`include "fsc_consts.vh"

// Overview of operation
// - Torch pin in torch mode: ceiling current, unmodulated
// - Focus enabled: focus current clamped to ceiling
// - Duty enable modulates focus current by duty
// - Strobe gate forces boost to fixed 5V
// - Count every second flash, saturating at maximum
// - Counter bytes ignore host writes
// - Non-volatile write needs unlock key first
// - Key cleared after programming; host waits
// - Defer write while hot; old value reads
// - Glitch filter drops pulses under minimum width
// - Strobe over 2ms: timeout fault, gate off
// - Stretch gate by programmed cycles; zero disables
// - Self test starts on start bit in active
// - Healthy self test leaves status 40h
// - Start bit clears when self test ends
// - Stop needs start cleared then standby cleared
// - Reset command; host waits 4ms afterwards
// - Fault stops boost, charger, sources; standby
// - No active or torch until faults read
// - Interrupt low on unmasked status; read clears
// - Charge monitor at FFh: timeout fault, charger off
module fsc_top #(
  parameter TIMEOUT_CYC = (`FSC_TIMEOUT_US * 1000) / `FSC_CLK_NS,
  parameter NVM_PROG_CYC = (`FSC_NVM_PROG_US * 1000) / `FSC_CLK_NS,
  parameter [7:0] UNLOCK_KEY = 8'h5a // Arbitrary value
) (
  // Clock and reset
  input wire mclk,
  input wire resetn,
  // Register access port
  input wire reg_wr,
  input wire reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  output reg [7:0] reg_rdata_q,
  // Pins and analog status
  input wire strobe_in,
  input wire torch_in,
  input wire die_hot,
  input wire charging,
  input wire charge_tick,
  input wire [4:0] fault_in,
  // Outputs to power stages
  output reg [7:0] lamp_cur_q,
  output reg lamp_on_q,
  output reg boost_en_q,
  output reg boost_5v_q,
  output reg charger_en_q,
  output reg switch_gate_drive_q,
  // Open-drain interrupt, enable low while pulling
  output reg int_out_q,
  output reg int_oe_n_q
);
  localparam [17:0] FILT_CYC = (`FSC_STROBE_MIN_NS + `FSC_CLK_NS - 1) / `FSC_CLK_NS;
  localparam [17:0] TO_CYC = TIMEOUT_CYC;
  localparam [17:0] PROG_CYC = NVM_PROG_CYC;
  localparam [17:0] STEP_CYC = (`FSC_ST_STEP_US * 1000) / `FSC_CLK_NS;
  localparam ST_IDLE = 2'h0;
  localparam ST_RUN = 2'h1;
  localparam ST_LAST = 2'h2;

  reg [7:0] devctl_q, lampctl_q, ceil_q, fcur_q, duty_q, stretch_q;
  reg [7:0] key_q, nvm_q, nvm_pend_q, status_q, mask_q, pwm_q, chg_q;
  reg [15:0] cnt_q;
  reg active_q, parity_q, prog_q, wpend_q, cpend_q, abort_q, filt_q, to_q;
  reg [17:0] filt_cnt_q, to_cnt_q, prog_cnt_q, st_cnt_q;
  reg [7:0] ext_q;
  reg [2:0] step_q;
  reg [1:0] st_q;

  wire wr_dc = reg_wr && (reg_addr == `FSC_A_DEVCTL);
  wire wr_lc = reg_wr && (reg_addr == `FSC_A_LAMPCTL);
  wire rd_st = reg_rd && (reg_addr == `FSC_A_STATUS);
  wire soft_rst = wr_dc && (reg_wdata == `FSC_DC_RESET_CMD);
  wire fault_any = (status_q[`FSC_ST_EXT_HI:`FSC_ST_TOF] != 6'h00);
  wire flash_end = filt_q && !strobe_in;
  wire to_hit = filt_q && !to_q && (to_cnt_q == TO_CYC - 18'h1);
  wire chg_hit = charging && charge_tick && (chg_q == `FSC_CHG_MAX - 8'h01);
  wire new_fault = to_hit || chg_hit || (fault_in != 5'h00);
  wire st_done = (st_q == ST_LAST) && (st_cnt_q == STEP_CYC);
  wire st_stop = abort_q && wr_dc && !reg_wdata[`FSC_DC_STANDBY_REQUEST];
  // Standby entry resets device and lamp control; the reset command all control registers
  wire go_standby_request = new_fault || (wr_dc && reg_wdata[`FSC_DC_STANDBY_REQUEST]) || soft_rst;
  // Status clears on a read, a standby request or the reset command
  wire st_clr = rd_st || (wr_dc && reg_wdata[`FSC_DC_STANDBY_REQUEST]) || soft_rst;

  // Control registers written by the host
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      devctl_q <= `FSC_RST_BYTE;
      lampctl_q <= `FSC_RST_BYTE;
      ceil_q <= `FSC_RST_BYTE;
      fcur_q <= `FSC_RST_BYTE;
      duty_q <= `FSC_RST_BYTE;
      stretch_q <= `FSC_RST_BYTE;
      mask_q <= `FSC_RST_MASK;
    end else if (go_standby_request) begin
      devctl_q <= `FSC_RST_BYTE;
      lampctl_q <= `FSC_RST_BYTE;
      if (soft_rst) begin
        ceil_q <= `FSC_RST_BYTE;
        fcur_q <= `FSC_RST_BYTE;
        duty_q <= `FSC_RST_BYTE;
        stretch_q <= `FSC_RST_BYTE;
        mask_q <= `FSC_RST_MASK;
      end
    end else begin
      if (wr_dc) begin
        devctl_q <= reg_wdata;
      end else if (st_done || (st_stop && st_q == ST_IDLE)) begin
        devctl_q[`FSC_DC_MST] <= 1'b0;
      end
      if (wr_lc) begin
        lampctl_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_CEIL) begin
        ceil_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_FCUR) begin
        fcur_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_DUTY) begin
        duty_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_STRETCH) begin
        stretch_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_MASK) begin
        mask_q <= reg_wdata;
      end
    end
  end

  // Active mode, entered by lamp activity only when no fault is latched
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      active_q <= 1'b0;
    end else if (go_standby_request) begin
      active_q <= 1'b0;
    end else if (wr_lc && (reg_wdata[`FSC_LC_FOCUS] || reg_wdata[`FSC_LC_GATE])) begin
      active_q <= !fault_any;
    end
  end

  // Status: set wins over the read-clear so no event is lost
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      status_q <= `FSC_RST_BYTE;
    end else begin
      status_q <= st_clr ? `FSC_RST_BYTE : status_q;
      if (to_hit || chg_hit) begin
        status_q[`FSC_ST_TOF] <= 1'b1;
      end
      status_q[`FSC_ST_EXT_HI:`FSC_ST_EXT_LO] <= (st_clr ? 5'h00 :
        status_q[`FSC_ST_EXT_HI:`FSC_ST_EXT_LO]) | fault_in;
      if (st_done) begin
        status_q[`FSC_ST_DONE] <= 1'b1;
      end
    end
  end

  // Charge time monitor runs only while the capacitor charges
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      chg_q <= `FSC_RST_BYTE;
    end else if (!charging) begin
      chg_q <= `FSC_RST_BYTE;
    end else if (charge_tick && chg_q != `FSC_CHG_MAX) begin
      chg_q <= chg_q + 8'h01;
    end
  end

  // Strobe glitch filter, timeout and stretch; output gate from one flop
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      filt_cnt_q <= 18'h0;
      filt_q <= 1'b0;
      to_cnt_q <= 18'h0;
      to_q <= 1'b0;
      ext_q <= `FSC_RST_BYTE;
      switch_gate_drive_q <= 1'b0;
    end else begin
      if (!strobe_in) begin
        filt_cnt_q <= 18'h0;
        filt_q <= 1'b0;
      end else if (filt_cnt_q < FILT_CYC) begin
        filt_cnt_q <= filt_cnt_q + 18'h1;
      end else begin
        filt_q <= 1'b1;
      end
      to_cnt_q <= filt_q ? to_cnt_q + {17'h0, !to_q} : 18'h0;
      if (to_hit) begin
        to_q <= 1'b1;
      end else if (!filt_q) begin
        to_q <= 1'b0;
      end
      if (filt_q && strobe_in) begin
        ext_q <= stretch_q;
      end else if (ext_q != 8'h00) begin
        ext_q <= ext_q - 8'h01;
      end
      switch_gate_drive_q <= !to_hit && !to_q && !fault_any &&
        ((filt_q && strobe_in) || (ext_q != 8'h00));
    end
  end

  // Flash counter and unlock-protected non-volatile byte
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      cnt_q <= 16'h0;
      parity_q <= 1'b0;
      key_q <= `FSC_RST_BYTE;
      nvm_q <= `FSC_RST_BYTE;
      nvm_pend_q <= `FSC_RST_BYTE;
      wpend_q <= 1'b0;
      cpend_q <= 1'b0;
      prog_q <= 1'b0;
      prog_cnt_q <= 18'h0;
    end else begin
      if (flash_end) begin
        parity_q <= !parity_q;
        if (parity_q && cnt_q != `FSC_CNT_MAX) begin
          cnt_q <= cnt_q + 16'h1;
          cpend_q <= 1'b1;
        end
      end
      if (reg_wr && reg_addr == `FSC_A_KEY && !prog_q) begin
        key_q <= reg_wdata;
      end
      if (reg_wr && reg_addr == `FSC_A_NVM && key_q == UNLOCK_KEY && !wpend_q) begin
        nvm_pend_q <= reg_wdata;
        wpend_q <= 1'b1;
      end
      if (!prog_q && !die_hot && (wpend_q || cpend_q)) begin
        prog_q <= 1'b1;
        prog_cnt_q <= 18'h0;
      end else if (prog_q && prog_cnt_q == PROG_CYC - 18'h1) begin
        prog_q <= 1'b0;
        cpend_q <= 1'b0;
        if (wpend_q) begin
          nvm_q <= nvm_pend_q;
          wpend_q <= 1'b0;
          key_q <= `FSC_RST_BYTE;
        end
      end else if (prog_q) begin
        prog_cnt_q <= prog_cnt_q + 18'h1;
      end
    end
  end

  // Self test sequencer; an abort finishes the step in progress
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      st_q <= ST_IDLE;
      st_cnt_q <= 18'h0;
      step_q <= 3'h0;
      abort_q <= 1'b0;
    end else begin
      if (wr_dc && !reg_wdata[`FSC_DC_MST] && st_q != ST_IDLE) begin
        abort_q <= 1'b1;
      end else if (st_q == ST_IDLE) begin
        abort_q <= 1'b0;
      end
      case (st_q)
        ST_IDLE: begin
          if (devctl_q[`FSC_DC_MST] && active_q && !fault_any) begin
            st_q <= ST_RUN;
            st_cnt_q <= 18'h0;
            step_q <= 3'h0;
          end
        end
        ST_RUN: begin
          if (st_cnt_q == STEP_CYC) begin
            st_cnt_q <= 18'h0;
            step_q <= step_q + 3'h1;
            if (step_q == `FSC_ST_STEPS - 3'h2) begin
              st_q <= ST_LAST;
            end
          end else begin
            st_cnt_q <= st_cnt_q + 18'h1;
          end
          if (st_stop || fault_any) begin
            st_q <= ST_LAST;
          end
        end
        ST_LAST: begin
          st_cnt_q <= st_done ? 18'h0 : st_cnt_q + 18'h1;
          if (st_done) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Lamp source selection, duty modulation and power stage enables
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pwm_q <= `FSC_RST_BYTE;
      lamp_cur_q <= `FSC_RST_BYTE;
      lamp_on_q <= 1'b0;
      boost_en_q <= 1'b0;
      boost_5v_q <= 1'b0;
      charger_en_q <= 1'b0;
    end else begin
      pwm_q <= pwm_q + 8'h01;
      lamp_on_q <= 1'b0;
      lamp_cur_q <= `FSC_RST_BYTE;
      if (fault_any || new_fault) begin
        boost_en_q <= 1'b0;
        boost_5v_q <= 1'b0;
      end else if (lampctl_q[`FSC_LC_FOCUS] || lampctl_q[`FSC_LC_GATE]) begin
        lamp_cur_q <= (fcur_q > ceil_q) ? ceil_q : fcur_q;
        lamp_on_q <= (!lampctl_q[`FSC_LC_GATE] || strobe_in) &&
          (!lampctl_q[`FSC_LC_DUTY_EN] || (pwm_q < duty_q));
        boost_en_q <= 1'b1;
        boost_5v_q <= lampctl_q[`FSC_LC_GATE];
      end else if (torch_in && !active_q) begin
        lamp_cur_q <= ceil_q;
        lamp_on_q <= 1'b1;
        boost_en_q <= 1'b1;
        boost_5v_q <= 1'b0;
      end else begin
        boost_en_q <= 1'b0;
        boost_5v_q <= 1'b0;
      end
      charger_en_q <= charging && !fault_any && !new_fault;
    end
  end

  // Read data and open-drain interrupt
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      reg_rdata_q <= `FSC_RST_BYTE;
      int_out_q <= 1'b0;
      int_oe_n_q <= 1'b1;
    end else begin
      int_out_q <= 1'b0;
      int_oe_n_q <= rd_st || ((status_q & ~mask_q) == 8'h00);
      if (reg_rd) begin
        case (reg_addr)
          `FSC_A_DEVCTL: reg_rdata_q <= devctl_q;
          `FSC_A_LAMPCTL: reg_rdata_q <= lampctl_q;
          `FSC_A_CEIL: reg_rdata_q <= ceil_q;
          `FSC_A_FCUR: reg_rdata_q <= fcur_q;
          `FSC_A_DUTY: reg_rdata_q <= duty_q;
          `FSC_A_STRETCH: reg_rdata_q <= stretch_q;
          `FSC_A_KEY: reg_rdata_q <= key_q;
          `FSC_A_NVM: reg_rdata_q <= nvm_q;
          `FSC_A_CNT_HI: reg_rdata_q <= cnt_q[15:8];
          `FSC_A_CNT_LO: reg_rdata_q <= cnt_q[7:0];
          `FSC_A_STATUS: reg_rdata_q <= status_q;
          `FSC_A_MASK: reg_rdata_q <= mask_q;
          default: reg_rdata_q <= `FSC_RST_BYTE;
        endcase
      end
    end
  end
endmodule // fsc_top

// *** verilog/fsc_consts.vh ***
// Constants for the flash strobe control block: register offsets,
// field positions, reset values and timing figures.
// Assumes a 125 MHz mclk (8 ns period).
`ifndef FSC_CONSTS_VH
`define FSC_CONSTS_VH
// Clock period in ns
`define FSC_CLK_NS 8
// Register offsets
`define FSC_A_DEVCTL 8'h04
`define FSC_A_LAMPCTL 8'h11
`define FSC_A_CEIL 8'h12
`define FSC_A_FCUR 8'h13
`define FSC_A_DUTY 8'h14
`define FSC_A_STRETCH 8'h15
`define FSC_A_KEY 8'h20
`define FSC_A_NVM 8'h21
`define FSC_A_CNT_HI 8'h22
`define FSC_A_CNT_LO 8'h23
`define FSC_A_STATUS 8'h30
`define FSC_A_MASK 8'h31
// device_control fields
`define FSC_DC_STANDBY_REQUEST 0
`define FSC_DC_MST 2
`define FSC_DC_RESET_CMD 8'h40
// lamp_control fields
`define FSC_LC_FOCUS 3
`define FSC_LC_GATE 4
`define FSC_LC_DUTY_EN 5
// Status fields
`define FSC_ST_TOF 0
`define FSC_ST_EXT_LO 1
`define FSC_ST_EXT_HI 5
`define FSC_ST_DONE 6
// Reset values and counter limits
`define FSC_RST_BYTE 8'h00
`define FSC_RST_MASK 8'h00
`define FSC_CNT_MAX 16'hffff
`define FSC_CHG_MAX 8'hff
// Timing figures
`define FSC_STROBE_MIN_NS 200
`define FSC_TIMEOUT_US 2000
`define FSC_NVM_PROG_US 1000
`define FSC_ST_STEP_US 100
`define FSC_ST_STEPS 3'h4
`endif

// *** bench/fsc_monitor.sv ***
// Checker for fsc_top: faults, interrupt, strobe filter and timeout, boost mode.
// Assumes the interrupt mask keeps its reset value throughout the run.
`timescale 1ns/100ps
module fsc_monitor #(parameter TIMEOUT_CYC = 250000) (
  // Clock, reset and register port
  input wire mclk, resetn, reg_wr, reg_rd,
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  // Pins
  input wire strobe_in, charging, charge_tick,
  input wire [4:0] fault_in,
  // Outputs
  input wire lamp_on_q, boost_en_q, boost_5v_q, charger_en_q,
  input wire switch_gate_drive_q, int_out_q, int_oe_n_q
);
  reg [19:0] run_q;
  reg strobe_prev_q;
  reg [7:0] tick_q;
  reg pend_q;
  wire st_rd = reg_rd && reg_addr == 8'h30;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!resetn);
  // Strobe run length held after the fall, charge ticks, unread fault
  always @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      run_q <= 20'h00000;
      strobe_prev_q <= 1'b0;
      tick_q <= 8'h00;
      pend_q <= 1'b0;
    end else begin
      strobe_prev_q <= strobe_in;
      if (strobe_in && !strobe_prev_q)
        run_q <= 20'h00001;
      else if (strobe_in && run_q != 20'hfffff)
        run_q <= run_q + 20'h00001;
      if (!charging)
        tick_q <= 8'h00;
      else if (charge_tick && tick_q != 8'hff)
        tick_q <= tick_q + 8'h01;
      // A new fault wins over a clear in the same cycle
      pend_q <= (|fault_in) || (pend_q && !st_rd && !(reg_wr && reg_addr == 8'h04));
    end
  end
  a_int_never_high:
    assert property (int_out_q == 1'b0) else $error("interrupt driven high");
  a_fault_stops_power:
    assert property (|fault_in |-> ##[1:3] (!boost_en_q && !charger_en_q && !lamp_on_q))
    else $error("power stages on after fault");
  a_fault_blocks_active:
    assert property (pend_q && $past(pend_q, 3) |-> !lamp_on_q && !boost_en_q)
    else $error("restart before fault read");
  a_fault_pulls_int:
    assert property (|fault_in |-> ##[1:3] !int_oe_n_q) else $error("interrupt not pulled");
  a_read_releases_int:
    assert property (st_rd && fault_in == 5'h00 && $past(fault_in) == 5'h00 && !strobe_in
      && !charging |-> ##[1:2] int_oe_n_q) else $error("interrupt held after read");
  a_glitch_filtered:
    assert property ($rose(switch_gate_drive_q) |-> run_q >= 20'd24)
    else $error("gate from short strobe");
  a_timeout_gate_off:
    assert property (strobe_in && run_q > TIMEOUT_CYC + 40 |-> !switch_gate_drive_q)
    else $error("gate on past timeout");
  a_charge_monitor_fault:
    assert property (charging && tick_q == 8'hff |-> ##[0:3] (!int_oe_n_q && !charger_en_q))
    else $error("charge monitor end missed");
  a_strobe_gate_5v:
    assert property (reg_wr && reg_addr == 8'h11 && reg_wdata[4] && !pend_q
      && fault_in == 5'h00 |-> ##[1:2] boost_5v_q) else $error("boost not in 5V mode");
endmodule // fsc_monitor
bind fsc_top fsc_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) fsc_monitor_inst (
  .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .strobe_in(strobe_in), .charging(charging),
  .charge_tick(charge_tick), .fault_in(fault_in), .lamp_on_q(lamp_on_q),
  .boost_en_q(boost_en_q), .boost_5v_q(boost_5v_q), .charger_en_q(charger_en_q),
  .switch_gate_drive_q(switch_gate_drive_q), .int_out_q(int_out_q), .int_oe_n_q(int_oe_n_q));

// *** bench/fsc_host.sv ***
// Host strobe source: one pulse of the commanded width per request.
// Assumes go is a one-cycle request set just after a falling edge.
`timescale 1ns/100ps
module fsc_host #(parameter GAP_CYC = 100) (
  // Clock and command
  input wire mclk,
  input wire go,
  input wire [19:0] width,
  output reg busy = 1'b0,
  // Strobe pin, pulled low when idle
  output reg strobe_in = 1'b0
);
  integer n = 0;
  // Pulse, then a quiet gap so counter updates never crowd each other
  always @(negedge mclk) begin
    if (go && !busy) begin
      busy <= 1'b1;
      strobe_in <= 1'b1;
      n <= 1;
    end else if (busy) begin
      n <= n + 1;
      if (n == width)
        strobe_in <= 1'b0;
      if (n == width + GAP_CYC)
        busy <= 1'b0;
    end
  end
endmodule // fsc_host

// *** bench/test_flash_strobe_control.sv ***
// Testbench for fsc_top: register tasks, strobe source, fault and self test.
// Assumes the checker is bound from its own file.
`timescale 1ns/100ps
module test_flash_strobe_control;
  reg mclk = 1'b0, resetn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, go = 1'b0;
  reg torch_in = 1'b0, die_hot = 1'b0, charging = 1'b0, charge_tick = 1'b0;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  reg [4:0] fault_in = 5'h00;
  reg [19:0] width = 20'h00000;
  wire [7:0] reg_rdata_q, lamp_cur_q;
  wire strobe_in, busy, lamp_on_q, boost_en_q, boost_5v_q, charger_en_q, gate, int_out_q;
  wire int_oe_n_q;
  integer fail_count = 0, comparisons = 0, gcnt = 0, ocnt = 0, g0, k;
  fsc_top #(.TIMEOUT_CYC(200), .NVM_PROG_CYC(50)) fsc_top_inst (
    .mclk(mclk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .strobe_in(strobe_in),
    .torch_in(torch_in), .die_hot(die_hot), .charging(charging), .charge_tick(charge_tick),
    .fault_in(fault_in), .lamp_cur_q(lamp_cur_q), .lamp_on_q(lamp_on_q),
    .boost_en_q(boost_en_q), .boost_5v_q(boost_5v_q), .charger_en_q(charger_en_q),
    .switch_gate_drive_q(gate), .int_out_q(int_out_q), .int_oe_n_q(int_oe_n_q));
  fsc_host #(.GAP_CYC(100)) fsc_host_inst (.mclk(mclk), .go(go), .width(width),
    .busy(busy), .strobe_in(strobe_in));
  // Clock
  initial forever #4 mclk = ~mclk;
  // Gate-high and lamp-on cycle counts, cleared by the scenarios
  always @(posedge mclk) begin
    gcnt <= gcnt + gate;
    ocnt <= ocnt + lamp_on_q;
  end
  task chk(input [7:0] g, input [7:0] e);
    begin
      comparisons = comparisons + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("CHECK FAILED at %0t: got %h want %h", $time, g, e);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(negedge mclk);
  endtask
  task wr(input [7:0] a, input [7:0] v);
    begin
      @(negedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(negedge mclk);
      reg_wr <= 1'b0;
    end
  endtask
  task rdc(input [7:0] a, input [7:0] e);
    begin
      @(negedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(negedge mclk);
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk(reg_rdata_q, e);
    end
  endtask
  // One strobe pulse; returns once the host model is idle again
  task flash(input [19:0] w);
    begin
      @(negedge mclk);
      gcnt = 0;
      width <= w;
      go <= 1'b1;
      @(negedge mclk);
      go <= 1'b0;
      for (k = 0; (busy !== 1'b0 || k < 2) && k < 2000; k = k + 1)
        @(negedge mclk);
    end
  endtask
  task end_of_test;
    begin
      $display("fail_count %0d comparisons %0d", fail_count, comparisons);
      if (fail_count == 0 && comparisons > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  // Watchdog sized for the self test plus the short scenarios
  initial begin
    #(8 * 90000);
    fail_count = fail_count + 1;
    end_of_test;
  end
  // Main sequence
  initial begin
    idle(3);
    resetn <= 1'b1;
    rdc(8'h04, 8'h00);
    rdc(8'hff, 8'h00);
    // Locked write refused, unlocked write deferred while hot
    wr(8'h21, 8'ha5);
    rdc(8'h21, 8'h00);
    wr(8'h20, 8'h5a);
    die_hot <= 1'b1;
    wr(8'h21, 8'ha5);
    idle(80);
    rdc(8'h21, 8'h00);
    die_hot <= 1'b0;
    idle(80);
    rdc(8'h21, 8'ha5);
    rdc(8'h20, 8'h00);
    // Glitch, plain, stretched and over-long strobes
    flash(20'd25);
    chk(gcnt == 0, 8'h01);
    flash(20'd60);
    g0 = gcnt;
    chk(g0 >= 30 && g0 <= 38, 8'h01);
    wr(8'h15, 8'd20);
    flash(20'd60);
    chk(gcnt >= g0 + 19 && gcnt <= g0 + 21, 8'h01);
    wr(8'h15, 8'h00);
    flash(20'd600);
    chk(gcnt >= 190 && gcnt <= 205, 8'h01);
    chk(int_oe_n_q, 8'h00);
    rdc(8'h30, 8'h01);
    chk(int_oe_n_q, 8'h01);
    wr(8'h23, 8'hff);
    rdc(8'h23, 8'h01);
    rdc(8'h22, 8'h00);
    // Focus clamp, duty, strobe-gated boost, torch
    wr(8'h12, 8'h40);
    wr(8'h13, 8'h80);
    wr(8'h11, 8'h08);
    idle(3);
    chk(lamp_cur_q, 8'h40);
    wr(8'h13, 8'h20);
    wr(8'h14, 8'h40);
    wr(8'h11, 8'h28);
    idle(3);
    ocnt = 0;
    idle(256);
    chk(lamp_cur_q, 8'h20);
    chk(ocnt >= 62 && ocnt <= 66, 8'h01);
    wr(8'h11, 8'h10);
    idle(3);
    chk(boost_5v_q, 8'h01);
    wr(8'h11, 8'h00);
    // Standby first: the torch pin only acts outside active mode
    wr(8'h04, 8'h01);
    torch_in <= 1'b1;
    idle(3);
    ocnt = 0;
    idle(256);
    chk(lamp_cur_q, 8'h40);
    chk(ocnt >= 255, 8'h01);
    // Fault with torch lit; restart refused until the status read
    fault_in <= 5'h01;
    idle(4);
    fault_in <= 5'h00;
    chk(int_oe_n_q, 8'h00);
    chk(lamp_on_q, 8'h00);
    wr(8'h11, 8'h08);
    idle(3);
    chk(lamp_on_q, 8'h00);
    torch_in <= 1'b0;
    rdc(8'h30, 8'h02);
    wr(8'h11, 8'h08);
    idle(3);
    chk(lamp_on_q, 8'h01);
    // Charge monitor running out
    charging <= 1'b1;
    repeat (256) begin
      idle(1);
      charge_tick <= 1'b1;
      idle(1);
      charge_tick <= 1'b0;
    end
    idle(3);
    chk(int_oe_n_q, 8'h00);
    charging <= 1'b0;
    idle(2);
    rdc(8'h30, 8'h01);
    // Self test from active mode, waited on through the interrupt
    wr(8'h11, 8'h08);
    wr(8'h11, 8'h00);
    wr(8'h04, 8'h04);
    rdc(8'h04, 8'h04);
    for (k = 0; int_oe_n_q !== 1'b0 && k < 60000; k = k + 1)
      @(negedge mclk);
    rdc(8'h04, 8'h00);
    rdc(8'h30, 8'h40);
    // Self test stopped early: start bit cleared, then standby request cleared
    wr(8'h04, 8'h04);
    wr(8'h04, 8'h00);
    wr(8'h04, 8'h00);
    for (k = 0; int_oe_n_q !== 1'b0 && k < 20000; k = k + 1)
      @(negedge mclk);
    chk(k > 12400 && k < 12600, 8'h01);
    rdc(8'h30, 8'h40);
    // Reset command returns the settings to their defaults
    wr(8'h04, 8'h40);
    idle(10);
    rdc(8'h12, 8'h00);
    end_of_test;
  end
endmodule // test_flash_strobe_control
